// *** src/ievt_pkg.sv ***
// Purpose: Constants for the I2C event status register bank
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: Bit positions shared by flag and new-event registers
package ievt_pkg;
	// Register byte addresses
	localparam logic [31:0] EVT_OFF = 32'h0001_d300;
	localparam logic [31:0] CTRL_OFF = 32'h0001_d304;
	localparam logic [31:0] NEW_OFF = 32'h0001_d308;
	// Implemented event bits; reserved bits read as zero
	localparam logic [31:0] EVT_MASK = 32'hfcfa_7bee;
	localparam logic [31:0] EVT_RST = 32'h0000_0000;
	localparam logic [31:0] NEW_RST = 32'h0000_0000;
	localparam logic CTRL_RST = 1'h0;
	// Event bit positions, and the soft reset control bit
	localparam int unsigned BOOT_ERR_BIT = 20;
	localparam int unsigned BOOT_OK_BIT = 23;
	localparam int unsigned NACK_BIT = 26;
	localparam int unsigned COL_BIT = 27;
	localparam int unsigned XACT_TO_BIT = 28;
	localparam int unsigned BYTE_TO_BIT = 29;
	localparam int unsigned CLK_LOW_TO_BIT = 30;
	localparam int unsigned ARB_TO_BIT = 31;
	localparam int unsigned SOFT_RST_BIT = 0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : ievt_pkg

// *** src/ievt_regs.sv ***
// Purpose: I2C event flags and new-event capture behind AXI4-Lite
// Assumes: Event inputs are one-cycle pulses synchronous to aclk
// Notes: One write and one read in flight at most
// Operation
// - Boot load finished cleanly sets boot-success flag, bit 23.
// - Boot load disabled at power-up also sets boot-success flag.
// - Master NACK, software or boot transfer, sets bit 26.
// - Master arbitration lost after addressing sets bit 27.
// - Whole-transaction timer expiry sets bit 28.
// - Per-byte timer expiry sets bit 29.
// - Clock-low timer expiry sets bit 30.
// - Arbitration timer expiry sets bit 31.
// - New-event register records events since last snapshot, same bits.
// - Writing one to new-event bit sets it; zero leaves it.
// - Event register write or snapshot clears whole new-event register.
// - Soft reset bit set holds new-event register at zero.
// - New-event bits 1..3 slave done events; bit 0 reserved.
// - New-event bits 5,6 diagnostic events; bit 4 reserved.
// - Boot read failure sets boot-error flag, bit 20.
`timescale 1ns/100ps
module ievt_regs (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic [31:0] awaddr, // Write address
	input wire logic [2:0] awprot, // Unused
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [31:0] araddr, // Read address
	input wire logic [2:0] arprot, // Unused
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic boot_ok_evt, // Boot load done, no error
	input wire logic boot_err_evt, // Boot load register read failed
	input wire logic boot_load_disabled, // Strap level
	input wire logic m_nack_evt, // Master got NACK
	input wire logic m_collision_evt, // Master lost arbitration
	input wire logic m_xact_to_evt, // Transaction timer expired
	input wire logic m_byte_to_evt, // Byte timer expired
	input wire logic m_clk_low_to_evt, // Clock-low timer expired
	input wire logic m_arb_to_evt, // Arbitration timer expired
	input wire logic [31:0] other_evt, // Remaining event pulses
	input wire logic snapshot_pulse, // Interrupt status read
	output logic [31:0] event_flags, // Event flag register
	output logic [31:0] new_events, // New-event register
	output logic soft_reset_bit // Soft reset control
);
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [31:0] waddr_r, waddr_nxt, wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [31:0] evt_r, evt_nxt, new_r, new_nxt;
	logic soft_rst_r, soft_rst_nxt, strap_done_r, strap_done_nxt;
	logic [31:0] wmask, hw_set, evt_clr, new_w1s, waddr_w, raddr_w;
	logic do_wr, wr_evt, wr_new, wr_ctrl, wr_hit, strap_set;

	// Byte strobes to bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
		end
	endgenerate

	assign awready = !aw_got_r && !bvalid_r;
	assign wready = !w_got_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	assign event_flags = evt_r;
	assign new_events = new_r;
	assign soft_reset_bit = soft_rst_r;

	assign waddr_w = {waddr_r[31:2], 2'h0};
	assign raddr_w = {araddr[31:2], 2'h0};
	assign do_wr = aw_got_r && w_got_r && !bvalid_r;
	assign wr_evt = do_wr && (waddr_w == ievt_pkg::EVT_OFF);
	assign wr_new = do_wr && (waddr_w == ievt_pkg::NEW_OFF);
	assign wr_ctrl = do_wr && (waddr_w == ievt_pkg::CTRL_OFF);
	assign wr_hit = (waddr_w == ievt_pkg::EVT_OFF)
		|| (waddr_w == ievt_pkg::NEW_OFF)
		|| (waddr_w == ievt_pkg::CTRL_OFF);
	assign strap_set = !strap_done_r && boot_load_disabled;

	// Write channel: address and data in either order
	always_comb begin : wr_comb
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (awvalid && awready) begin
			aw_got_nxt = 1'b1;
			waddr_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = wdata;
			wstrb_nxt = wstrb;
		end
		if (do_wr) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? ievt_pkg::RESP_OKAY : ievt_pkg::RESP_DECERR;
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 32'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= ievt_pkg::RESP_OKAY;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Read channel, no side effects
	always_comb begin : rd_comb
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = ievt_pkg::RESP_OKAY;
			case (raddr_w)
				ievt_pkg::EVT_OFF: rdata_nxt = evt_r;
				ievt_pkg::NEW_OFF: rdata_nxt = new_r;
				ievt_pkg::CTRL_OFF: rdata_nxt = {31'h0, soft_rst_r};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = ievt_pkg::RESP_DECERR;
				end
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= ievt_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Event flags and new-event capture
	always_comb begin : evt_comb
		hw_set = other_evt;
		hw_set[ievt_pkg::BOOT_OK_BIT] = other_evt[ievt_pkg::BOOT_OK_BIT]
			|| boot_ok_evt || strap_set;
		hw_set[ievt_pkg::BOOT_ERR_BIT] = other_evt[ievt_pkg::BOOT_ERR_BIT]
			|| boot_err_evt;
		hw_set[ievt_pkg::NACK_BIT] = other_evt[ievt_pkg::NACK_BIT]
			|| m_nack_evt;
		hw_set[ievt_pkg::COL_BIT] = other_evt[ievt_pkg::COL_BIT]
			|| m_collision_evt;
		hw_set[ievt_pkg::XACT_TO_BIT] = other_evt[ievt_pkg::XACT_TO_BIT]
			|| m_xact_to_evt;
		hw_set[ievt_pkg::BYTE_TO_BIT] = other_evt[ievt_pkg::BYTE_TO_BIT]
			|| m_byte_to_evt;
		hw_set[ievt_pkg::CLK_LOW_TO_BIT] =
			other_evt[ievt_pkg::CLK_LOW_TO_BIT] || m_clk_low_to_evt;
		hw_set[ievt_pkg::ARB_TO_BIT] = other_evt[ievt_pkg::ARB_TO_BIT]
			|| m_arb_to_evt;
		hw_set = hw_set & ievt_pkg::EVT_MASK;
		evt_clr = wr_evt ? (wdata_r & wmask) : 32'h0;
		evt_nxt = ((evt_r & ~evt_clr) | hw_set) & ievt_pkg::EVT_MASK;
		new_w1s = wr_new ? (wdata_r & wmask & ievt_pkg::EVT_MASK) : 32'h0;
		new_nxt = (wr_evt || snapshot_pulse) ? 32'h0 : new_r;
		new_nxt = new_nxt | hw_set | new_w1s;
		if (soft_rst_r) begin
			new_nxt = 32'h0;
		end
		soft_rst_nxt = soft_rst_r;
		if (wr_ctrl && wstrb_r[0]) begin
			soft_rst_nxt = wdata_r[ievt_pkg::SOFT_RST_BIT];
		end
		strap_done_nxt = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_r <= ievt_pkg::EVT_RST;
			new_r <= ievt_pkg::NEW_RST;
			soft_rst_r <= ievt_pkg::CTRL_RST;
			strap_done_r <= 1'b0;
		end else begin
			evt_r <= evt_nxt;
			new_r <= new_nxt;
			soft_rst_r <= soft_rst_nxt;
			strap_done_r <= strap_done_nxt;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_BOOT_OK: assert property (
		boot_ok_evt |=> evt_r[ievt_pkg::BOOT_OK_BIT])
		else $error("boot ok event not flagged");
	AST_BOOT_DIS: assert property (
		(!strap_done_r && boot_load_disabled) |=>
		evt_r[ievt_pkg::BOOT_OK_BIT] && strap_done_r)
		else $error("boot disabled strap not flagged");
	AST_NACK: assert property (
		m_nack_evt |=> evt_r[ievt_pkg::NACK_BIT])
		else $error("master nack not flagged");
	AST_COL: assert property (
		m_collision_evt |=> evt_r[ievt_pkg::COL_BIT])
		else $error("master collision not flagged");
	AST_XACT_TO: assert property (
		m_xact_to_evt |=> evt_r[ievt_pkg::XACT_TO_BIT])
		else $error("transaction timeout not flagged");
	AST_BYTE_TO: assert property (
		m_byte_to_evt |=> evt_r[ievt_pkg::BYTE_TO_BIT])
		else $error("byte timeout not flagged");
	AST_CLK_LOW_TO: assert property (
		m_clk_low_to_evt |=> evt_r[ievt_pkg::CLK_LOW_TO_BIT])
		else $error("clock low timeout not flagged");
	AST_ARB_TO: assert property (
		m_arb_to_evt |=> evt_r[ievt_pkg::ARB_TO_BIT])
		else $error("arbitration timeout not flagged");
	AST_BOOT_ERR: assert property (
		boot_err_evt |=> evt_r[ievt_pkg::BOOT_ERR_BIT])
		else $error("boot error not flagged");
	AST_W1C: assert property (
		(wr_evt && (hw_set == 32'h0)) |=>
		((evt_r & $past(evt_clr)) == 32'h0)
		&& (evt_r == ($past(evt_r) & ~$past(evt_clr))))
		else $error("event flag write one clear wrong");
	AST_RSVD: assert property (
		((evt_r | new_r) & ~ievt_pkg::EVT_MASK) == 32'h0)
		else $error("reserved bit set");
	AST_NEW_REC: assert property (
		(!soft_rst_r && (hw_set != 32'h0)) |=>
		((new_r & $past(hw_set)) == $past(hw_set)))
		else $error("event missing from new-event register");
	AST_NEW_W1S: assert property (
		(wr_new && !soft_rst_r) |=>
		((new_r & $past(new_w1s)) == $past(new_w1s))
		&& ((new_r & ~$past(new_r | new_w1s | hw_set)) == 32'h0))
		else $error("new-event write one set wrong");
	AST_NEW_CLR: assert property (
		((wr_evt || snapshot_pulse) && (hw_set == 32'h0)) |=>
		(new_r == ($past(new_w1s) & {32{!$past(soft_rst_r)}})))
		else $error("new-event register not cleared");
	AST_SOFT_RST: assert property (
		soft_rst_r |=> (new_r == 32'h0))
		else $error("new-event bit set under soft reset");
	AST_NEW_READ: assert property (
		(arvalid && arready && (raddr_w == ievt_pkg::NEW_OFF)) |=>
		rvalid_r && (rdata_r == $past(new_r))
		&& (rresp_r == ievt_pkg::RESP_OKAY))
		else $error("new-event read data wrong");
	AST_BRESP: assert property (
		do_wr |=> bvalid_r && !awready && !wready)
		else $error("write response late");

	COV_W1C: cover property (wr_evt && (evt_clr != 32'h0));
	COV_SNAP: cover property (snapshot_pulse && (new_r != 32'h0));
	COV_W1S: cover property (wr_new ##1 (new_r != 32'h0));
	COV_SET_CLR: cover property (wr_evt && (hw_set != 32'h0));
endmodule : ievt_regs

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the I2C event status registers
// Assumes: AXI4-Lite master tasks, event pulses one cycle wide
// Notes: Strap tied high so boot-success is set after reset
`timescale 1ns/100ps
module tb;
	logic aclk = 0, aresetn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, other_evt = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, soft_reset_bit;
	logic [1:0] bresp, rresp, r;
	logic [7:0] ev = 0;
	logic strap = 1, snap = 0;
	logic [3:0] ws = 4'hf;
	logic [31:0] event_flags, new_events, d;
	int failures = 0, num_checks = 0, cyc = 0;
	int bits[8];
	always #5 aclk = ~aclk;
	ievt_regs ievt_regs_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(ws), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.boot_ok_evt(ev[0]), .boot_err_evt(ev[1]), .boot_load_disabled(strap),
		.m_nack_evt(ev[2]), .m_collision_evt(ev[3]), .m_xact_to_evt(ev[4]),
		.m_byte_to_evt(ev[5]), .m_clk_low_to_evt(ev[6]),
		.m_arb_to_evt(ev[7]), .other_evt(other_evt), .snapshot_pulse(snap),
		.event_flags(event_flags), .new_events(new_events),
		.soft_reset_bit(soft_reset_bit));
	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [31:0] a, dt, output logic [1:0] rs);
		logic ad, wd;
		@(posedge aclk);
		ad = 0;
		wd = 0;
		awaddr <= a; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 0;
			end
			if (!wd && wready) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask : axw
	task automatic axr(input logic [31:0] a, output logic [31:0] dt,
		output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dt = rdata;
		rs = rresp;
		rready <= 0;
	endtask : axr
	task automatic t_reset;
		@(negedge aclk);
		chk(event_flags, 32'h0080_0000, "strap boot ok");
		chk(soft_reset_bit, 1'h0, "ctrl reset");
		axr(ievt_pkg::EVT_OFF, d, r);
		chk(d, 32'h0080_0000, "flag read reserved zero");
		axw(ievt_pkg::EVT_OFF, 32'hffff_ffff, r);
		axr(ievt_pkg::NEW_OFF, d, r);
		chk(d, 32'h0000_0000, "new reg cleared");
		chk(r, ievt_pkg::RESP_OKAY, "new reg okay");
		$display("test reset done");
	endtask : t_reset
	task automatic t_events;
		for (int i = 0; i < 8; i++) begin
			ev <= 8'h01 << i;
			@(posedge aclk);
			ev <= 0;
			@(negedge aclk);
			chk(event_flags, 32'h1 << bits[i], "flag");
			chk(new_events, 32'h1 << bits[i], "new set");
			@(posedge aclk);
			axw(ievt_pkg::EVT_OFF, 32'h0, r);
			@(negedge aclk);
			chk(event_flags, 32'h1 << bits[i], "zero write keeps");
			chk(new_events, 32'h0, "evt write clears new");
			@(posedge aclk);
			axw(ievt_pkg::EVT_OFF, 32'h1 << bits[i], r);
			@(negedge aclk);
			chk(event_flags, 32'h0, "w1c clears");
			@(posedge aclk);
		end
		$display("test events done");
	endtask : t_events
	task automatic t_new;
		axw(ievt_pkg::NEW_OFF, 32'h0000_007f, r);
		axw(ievt_pkg::NEW_OFF, 32'h0, r);
		axr(ievt_pkg::NEW_OFF, d, r);
		chk(d, 32'h0000_006e, "w1s low bits");
		snap <= 1;
		@(posedge aclk);
		snap <= 0;
		other_evt <= 32'h0000_0002;
		@(posedge aclk);
		other_evt <= 0;
		@(negedge aclk);
		chk(new_events, 32'h0000_0002, "snapshot then event");
		@(posedge aclk);
		$display("test new-event done");
	endtask : t_new
	task automatic t_soft;
		axw(ievt_pkg::CTRL_OFF, 32'h1, r);
		ev <= 8'h04;
		@(posedge aclk);
		ev <= 0;
		@(negedge aclk);
		chk(soft_reset_bit, 1'h1, "soft set");
		chk(new_events, 32'h0, "held clear");
		chk(event_flags, 32'h0400_0002, "flag still set");
		@(posedge aclk);
		axw(ievt_pkg::NEW_OFF, 32'h0000_006e, r);
		@(negedge aclk);
		chk(new_events, 32'h0, "w1s blocked");
		@(posedge aclk);
		axw(ievt_pkg::CTRL_OFF, 32'h0, r);
		ws <= 4'h7;
		axw(ievt_pkg::EVT_OFF, 32'hffff_ffff, r);
		@(negedge aclk);
		chk(event_flags, 32'h0400_0000, "strobe gates clear");
		@(posedge aclk);
		ws <= 4'hf;
		axw(ievt_pkg::EVT_OFF, 32'hffff_ffff, r);
		chk(event_flags, 32'h0, "flags cleared");
		$display("test soft reset done");
	endtask : t_soft
	task automatic t_unmapped;
		axr(32'h0001_d3f0, d, r);
		chk(d, 32'h0, "unmapped data");
		chk(r, ievt_pkg::RESP_DECERR, "unmapped read resp");
		axw(32'h0001_d3f0, 32'hffff_ffff, r);
		chk(r, ievt_pkg::RESP_DECERR, "unmapped write resp");
		$display("test unmapped done");
	endtask : t_unmapped
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		bits = '{ievt_pkg::BOOT_OK_BIT, ievt_pkg::BOOT_ERR_BIT,
			ievt_pkg::NACK_BIT, ievt_pkg::COL_BIT, ievt_pkg::XACT_TO_BIT,
			ievt_pkg::BYTE_TO_BIT, ievt_pkg::CLK_LOW_TO_BIT,
			ievt_pkg::ARB_TO_BIT};
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		t_reset();
		t_events();
		t_new();
		t_soft();
		t_unmapped();
		conclude();
	end
endmodule : tb
